// [hw/lrcr_bank.v]
// Five regulator control registers behind an APB slave, with decoded
// enable, sleep and voltage select outputs per regulator, plus decoded millivolts for regulator four.
// Assumes boot values arrive from nonvolatile configuration as pins
// that are stable around reset release.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`include "lrcr_map.vh"

module lrcr_bank (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // Boot configuration, one byte per regulator: four, five, six, seven, eight
    input wire [39:0] boot_cfg_i,
    // Regulator controls, index 0..4 = four, five, six, seven, eight; narrow select fields 0..3 = five, six, seven, eight
    output reg [4:0] reg_enable_o,
    output reg [4:0] reg_sleep_o,
    output reg [5:0] reg_four_sel_o,
    output reg [19:0] reg_narrow_sel_o,
    output reg [15:0] reg_four_mv_o,
    output reg reg_four_valid_o,
    output reg track_o
);

    // ------------------------------------------------------------
    // Boot configuration capture
    // ------------------------------------------------------------
    // Pins cross in through two flops before loading anything.
    reg [39:0] boot_meta_reg;
    reg [39:0] boot_sync_reg;
    reg [1:0] boot_cnt_reg;
    reg boot_done_reg;

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_meta_reg <= 40'h0000000000;
            boot_sync_reg <= 40'h0000000000;
        end else begin
            boot_meta_reg <= boot_cfg_i;
            boot_sync_reg <= boot_meta_reg;
        end
    end

    // Load happens once the synchroniser has filled after release
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_cnt_reg <= 2'h0;
            boot_done_reg <= 1'b0;
        end else if (!boot_done_reg) begin
            boot_cnt_reg <= boot_cnt_reg + 2'h1;
            if (boot_cnt_reg == 2'h2) begin
                boot_done_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg [7:0] ctrl_reg [0:4];
    reg track_reg;
    reg [2:0] idx_sel;
    reg hit_ctrl;
    reg hit_track;
    wire [9:0] word_addr;
    wire wr_go;
    wire rd_go;
    integer i;

    assign word_addr = paddr_i[11:2];
    assign wr_go = psel_i && penable_i && pwrite_i && pready_o;
    assign rd_go = psel_i && !penable_i && !pwrite_i;

    function [7:0] lrcr_mask;
        input [2:0] idx;
        begin
            if (idx == 3'h0) begin
                lrcr_mask = 8'hff;
            end else begin
                lrcr_mask = 8'h7f;
            end
        end
    endfunction

    always @* begin
        hit_ctrl = 1'b1;
        hit_track = 1'b0;
        idx_sel = 3'h0;
        case (word_addr)
            `LRCR_ADDR_FOUR: idx_sel = 3'h0;
            `LRCR_ADDR_FIVE: idx_sel = 3'h1;
            `LRCR_ADDR_SIX: idx_sel = 3'h2;
            `LRCR_ADDR_SEVEN: idx_sel = 3'h3;
            `LRCR_ADDR_EIGHT: idx_sel = 3'h4;
            `LRCR_ADDR_TRACK: begin
                hit_ctrl = 1'b0;
                hit_track = 1'b1;
            end
            default: hit_ctrl = 1'b0;
        endcase
    end

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (i = 0; i < 5; i = i + 1) begin
                ctrl_reg[i] <= `LRCR_RESET_VAL;
            end
            track_reg <= 1'b0;
        end else if (!boot_done_reg) begin
            if (boot_cnt_reg == 2'h2) begin
                for (i = 0; i < 5; i = i + 1) begin
                    ctrl_reg[i] <= boot_sync_reg[i*8 +: 8] & lrcr_mask(i[2:0]);
                end
            end
        end else if (wr_go && pstrb_i[0]) begin
            if (hit_ctrl) begin
                ctrl_reg[idx_sel] <= pwdata_i[7:0] & lrcr_mask(idx_sel);
            end
            if (hit_track) begin
                track_reg <= pwdata_i[0];
            end
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // No wait states: pready rises in the first access cycle.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !hit_ctrl && !hit_track;
            if (rd_go) begin
                if (hit_ctrl) begin
                    prdata_o <= {24'h000000, ctrl_reg[idx_sel]};
                end else if (hit_track) begin
                    prdata_o <= {31'h00000000, track_reg};
                end else begin
                    prdata_o <= 32'h00000000;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Regulator control outputs
    // ------------------------------------------------------------
    wire [15:0] four_mv;
    wire four_valid;

    lrcr_volt_decode u_four_dec (
        .sel_i(ctrl_reg[0][`LRCR_SEL6_MSB:`LRCR_SEL_LSB]),
        .wide_i(1'b1),
        .track_i(track_reg),
        .mv_o(four_mv),
        .valid_o(four_valid)
    );

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_enable_o <= 5'h00;
            reg_sleep_o <= 5'h00;
            reg_four_sel_o <= 6'h00;
            reg_narrow_sel_o <= 20'h00000;
            reg_four_mv_o <= 16'h0000;
            reg_four_valid_o <= 1'b0;
            track_o <= 1'b0;
        end else begin
            for (i = 0; i < 5; i = i + 1) begin
                reg_enable_o[i] <= ctrl_reg[i][`LRCR_ST_LSB];
                reg_sleep_o[i] <= (ctrl_reg[i][`LRCR_ST_MSB:`LRCR_ST_LSB] == `LRCR_ST_SLEEP);
            end
            for (i = 1; i < 5; i = i + 1) begin
                reg_narrow_sel_o[(i-1)*5 +: 5] <= ctrl_reg[i][`LRCR_SEL5_MSB:`LRCR_SEL_LSB];
            end
            reg_four_sel_o <= ctrl_reg[0][`LRCR_SEL6_MSB:`LRCR_SEL_LSB];
            reg_four_mv_o <= four_mv;
            reg_four_valid_o <= four_valid;
            track_o <= track_reg;
        end
    end

endmodule // lrcr_bank

// [hw/lrcr_map.vh]
// Register map constants for the linear regulator control register bank.
// Included by the bank and its decoder; definitions only.
`ifndef LRCR_MAP_VH
`define LRCR_MAP_VH

// Word offsets of the control registers
`define LRCR_OFF_FIVE 8'h32
`define LRCR_OFF_EIGHT 8'h33
`define LRCR_OFF_SEVEN 8'h34
`define LRCR_OFF_SIX 8'h35
`define LRCR_OFF_FOUR 8'h36

// Word indices compared against paddr[11:2] (byte address = 4 * offset)
`define LRCR_ADDR_FIVE 10'h032
`define LRCR_ADDR_EIGHT 10'h033
`define LRCR_ADDR_SEVEN 10'h034
`define LRCR_ADDR_SIX 10'h035
`define LRCR_ADDR_FOUR 10'h036
`define LRCR_ADDR_TRACK 10'h037

// Field positions
`define LRCR_ST_LSB 0
`define LRCR_ST_MSB 1
`define LRCR_SEL_LSB 2
`define LRCR_SEL5_MSB 6
`define LRCR_SEL6_MSB 7

// Supply state encodings
`define LRCR_ST_OFF0 2'h0
`define LRCR_ST_ACTIVE 2'h1
`define LRCR_ST_OFF1 2'h2
`define LRCR_ST_SLEEP 2'h3

// Nominal field reset value
`define LRCR_RESET_VAL 8'h00

// Voltage figures in mV and select code limits
`define LRCR_MV_MIN5 16'd1000
`define LRCR_MV_BASE5 16'd800
`define LRCR_MV_STEP5 16'd100
`define LRCR_SEL5_FLOOR 5'h03
`define LRCR_SEL5_TOP 5'h19
`define LRCR_MV_BASE6 16'd800
`define LRCR_MV_STEP6 16'd50
`define LRCR_SEL6_TOP 6'h32
`define LRCR_SEL6_TRK_LO 6'h00
`define LRCR_SEL6_TRK_HI 6'h0e
`define LRCR_SEL6_NRM_LO 6'h04

`endif

// [hw/lrcr_volt_decode.v]
// Decoder from a voltage select code to output millivolts and validity.
// Pure combinational; fed from registered fields in the same clock domain.
`timescale 1ns/100ps
`include "lrcr_map.vh"

module lrcr_volt_decode (
    // Code in
    input wire [5:0] sel_i,
    input wire wide_i,
    input wire track_i,
    // Result
    output reg [15:0] mv_o,
    output reg valid_o
);

    always @* begin
        mv_o = 16'h0000;
        valid_o = 1'b0;
        if (wide_i) begin
            mv_o = `LRCR_MV_BASE6 + `LRCR_MV_STEP6 * {10'h000, sel_i};
            if (track_i) begin
                valid_o = (sel_i <= `LRCR_SEL6_TRK_HI);
            end else begin
                valid_o = (sel_i >= `LRCR_SEL6_NRM_LO) && (sel_i <= `LRCR_SEL6_TOP);
            end
        end else begin
            if (sel_i[4:0] < `LRCR_SEL5_FLOOR) begin
                mv_o = `LRCR_MV_MIN5;
            end else begin
                mv_o = `LRCR_MV_BASE5 + `LRCR_MV_STEP5 * {11'h000, sel_i[4:0]};
            end
            valid_o = (sel_i[4:0] <= `LRCR_SEL5_TOP);
        end
    end

endmodule // lrcr_volt_decode

// [bench/lrcr_bank_sva.sv]
// Checker for the regulator control bank, bound to its ports.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/100ps
module lrcr_bank_sva (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [4:0] reg_enable_o,
    input wire logic [4:0] reg_sleep_o,
    input wire logic [19:0] reg_narrow_sel_o,
    input wire logic [15:0] reg_four_mv_o,
    input wire logic reg_four_valid_o,
    input wire logic track_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire [9:0] wa = paddr_i[11:2];
    wire [5:0] wsel = pwdata_i[7:2];
    wire mapped = wa >= 10'h032 && wa <= 10'h037;
    // ----------------------------------------
    // Handshake steps
    // ----------------------------------------
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_wr(a);
        psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && wa == a;
    endsequence
    a_ready_setup: assert property (s_setup |=> pready_o) else $error("ready late");
    a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held");
    a_err_map: assert property (pready_o |-> pslverr_o == !mapped) else $error("bad error");
    a_rsvd_zero: assert property (pready_o && !pwrite_i && wa >= 10'h032 && wa <= 10'h035
        |-> prdata_o[31:7] == 25'h0) else $error("reserved bit set");
    a_five_state: assert property (s_wr(10'h032) |-> ##2 reg_enable_o[1] == $past(pwdata_i[0], 2)
        && reg_sleep_o[1] == ($past(pwdata_i[1:0], 2) == 2'h3)) else $error("five state");
    a_five_sel: assert property (s_wr(10'h032) |-> ##2
        reg_narrow_sel_o[4:0] == $past(wsel[4:0], 2)) else $error("five code");
    a_eight_sel: assert property (s_wr(10'h033) |-> ##2
        reg_narrow_sel_o[19:15] == $past(wsel[4:0], 2)) else $error("eight code");
    a_four_mv: assert property (s_wr(10'h036) |-> ##2
        reg_four_mv_o == 16'd800 + 16'd50 * $past(wsel, 2)) else $error("four mv");
    a_four_valid: assert property (s_wr(10'h036) |-> ##2 reg_four_valid_o == (track_o ?
        $past(wsel, 2) <= 6'd14 : ($past(wsel, 2) >= 6'd4 && $past(wsel, 2) <= 6'd50))) else $error("four valid");
endmodule // lrcr_bank_sva

// [bench/linear_regulator_control_regs_tb_top.sv]
// Self-checking bench for the regulator control bank over APB.
// Assumes the bank answers each access within a few cycles.
`timescale 1ns/100ps
module linear_regulator_control_regs_tb_top;
    reg sys_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    reg [11:0] paddr_i = 0;
    reg [31:0] pwdata_i = 0, r;
    reg [3:0] pstrb_i = 0;
    reg [39:0] boot_cfg_i = 0;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, reg_four_valid_o, track_o;
    wire [4:0] reg_enable_o, reg_sleep_o;
    wire [5:0] reg_four_sel_o;
    wire [19:0] reg_narrow_sel_o;
    wire [15:0] reg_four_mv_o;
    integer seed = 32'hab61beb4, num_errors = 0, check_count = 0, i, n, k;
    reg [32:0] exp_q[$];
    reg [7:0] sh[0:5];
    reg [5:0] codes[0:5] = '{6'd14, 6'd15, 6'd3, 6'd4, 6'd50, 6'd51};
    always #5 sys_clk_i = ~sys_clk_i;
    lrcr_bank u_dut (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
        .prdata_o, .pready_o, .pslverr_o, .boot_cfg_i, .reg_enable_o, .reg_sleep_o, .reg_four_sel_o,
        .reg_narrow_sel_o, .reg_four_mv_o, .reg_four_valid_o, .track_o);
    task chk(input [32:0] seen, input [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Idle cycle after each transfer keeps one assignment per signal per step
    task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
        psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d; pstrb_i <= s;
        @(posedge sys_clk_i) penable_i <= 1;
        k = 0;
        do begin @(posedge sys_clk_i); k++; end while (pready_o !== 1'b1 && k < 20);
        if (k >= 20) begin num_errors++; final_report; end
        psel_i <= 0; penable_i <= 0;
        @(posedge sys_clk_i);
    endtask
    task rd(input [11:0] a, input [32:0] e);
        exp_q.push_back(e);
        apb(0, a, 32'h0, 4'hf);
    endtask
    always @(posedge sys_clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
            if (exp_q.size() == 0) chk(33'h1ffffffff, 33'h0);
            else chk({pslverr_o, prdata_o}, exp_q.pop_front());
        end
    end
    initial begin #1ms; num_errors++; final_report; end
    initial begin
        r = $random(seed);
        boot_cfg_i = {r[7:0], $random(seed)};
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 0;
        repeat (4) @(posedge sys_clk_i);
        sh[0] = boot_cfg_i[15:8] & 8'h7f; sh[1] = boot_cfg_i[39:32] & 8'h7f;
        sh[2] = boot_cfg_i[31:24] & 8'h7f; sh[3] = boot_cfg_i[23:16] & 8'h7f;
        sh[4] = boot_cfg_i[7:0]; sh[5] = 8'h00;
        for (n = 0; n < 4; n++) for (i = 0; i < 6; i++) begin
            if (n > 0) begin
                r = $random(seed);
                apb(1, 12'h0c8 + 12'(i * 4), r, 4'hf);
                sh[i] = i == 5 ? {7'h0, r[0]} : i == 4 ? r[7:0] : {1'b0, r[6:0]};
            end
            rd(12'h0c8 + 12'(i * 4), {25'h0, sh[i]});
        end
        for (i = 0; i < 4; i++) begin
            apb(1, 12'h0c8, 32'(i) | 32'h80, 4'hf);
            @(posedge sys_clk_i);
            chk({reg_enable_o[1], reg_sleep_o[1]}, {i[0], i == 3});
        end
        for (i = 0; i < 6; i++) begin
            apb(1, 12'h0dc, 32'(i < 2), 4'hf);
            apb(1, 12'h0d8, {24'h0, codes[i], 2'b01}, 4'hf);
            @(posedge sys_clk_i);
            chk(reg_four_valid_o, 33'(6'b011001 >> i & 1));
            chk(reg_four_mv_o, 33'd800 + 33'd50 * codes[i]);
            chk(reg_four_sel_o, {27'h0, codes[i]});
        end
        apb(1, 12'h0c8, 32'h7c, 4'he);
        rd(12'h0c8, 33'h03);
        apb(1, 12'h0e0, 32'hff, 4'hf);
        rd(12'h0e0, {1'b1, 32'h0});
        repeat (5) @(posedge sys_clk_i);
        chk(exp_q.size(), 33'h0);
        final_report;
    end
endmodule // linear_regulator_control_regs_tb_top
bind lrcr_bank lrcr_bank_sva u_sva (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .reg_enable_o, .reg_sleep_o, .reg_narrow_sel_o, .reg_four_mv_o,
    .reg_four_valid_o, .track_o);
